// >>> lag_pkg.sv
// Package: constants, register map and carrier types for the trunk distributor
package lag_pkg;
  localparam int NUM_PORTS   = 4;
  localparam int NUM_GROUPS  = 2;
  localparam int MIN_MEMBERS = 2;
  localparam int PORT_W      = 2;

  // Register word offsets (byte address = 4 * index)
  localparam logic [3:0] REG_GRP0_CFG   = 4'h0;
  localparam logic [3:0] REG_GRP1_CFG   = 4'h1;
  localparam logic [3:0] REG_DIST_CFG   = 4'h2;
  localparam logic [3:0] REG_PORT_STAT  = 4'h3;
  localparam logic [3:0] REG_GRP_STAT   = 4'h4;
  localparam logic [3:0] REG_LEAD_STP   = 4'h5;

  // Group config fields
  localparam int GCFG_MEMBER_LSB = 0;
  localparam int GCFG_ENABLE_BIT = 4;
  localparam int GCFG_DYNAMIC_BIT = 5;
  localparam int GCFG_SPEED_BIT  = 6;
  // Distribution config fields
  localparam int DCFG_NONIP_LSB  = 0;
  localparam int DCFG_IP_LSB     = 4;

  localparam logic [31:0] GCFG_RESET = 32'h0000_0000;
  localparam logic [31:0] DCFG_RESET = 32'h0000_0000;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hdead_0bad;

  typedef enum logic [2:0] {
    HASH_SRC_MAC     = 3'h0,
    HASH_DST_MAC     = 3'h1,
    HASH_SRC_DST_MAC = 3'h2,
    HASH_SOURCE_NET_ADDRESS_HASH      = 3'h3,
    HASH_DST_IP      = 3'h4,
    HASH_SRC_DST_IP  = 3'h5
  } hash_sel_t;

  typedef enum logic [1:0] {
    STP_FWD   = 2'h0,
    STP_BLOCK = 2'h1,
    STP_LEARN = 2'h2,
    STP_DIS   = 2'h3
  } stp_state_t;

  // Frame header presented for egress selection
  typedef struct packed {
    logic        valid;
    logic        is_ip;
    logic [47:0] src_mac;
    logic [47:0] dst_mac;
    logic [31:0] source_net_address_hash;
    logic [31:0] dst_ip;
    logic [1:0]  dest_port;
  } frame_hdr_t;

  // Egress decision
  typedef struct packed {
    logic       valid;
    logic       drop;
    logic [1:0] port;
  } egress_t;
endpackage

// >>> lag_hash.sv
// Combinational header hash folded to a small bucket index
`timescale 1ns/1ns
module lag_hash #(
  parameter int OUT_W = 8
) (
  input  wire logic [2:0]      i_sel,
  input  wire logic [47:0]     i_src_mac,
  input  wire logic [47:0]     i_dst_mac,
  input  wire logic [31:0]     i_source_net_address_hash,
  input  wire logic [31:0]     i_dst_ip,
  output logic      [OUT_W-1:0] o_hash
);
  logic [47:0] key;

  // Key chosen by distribution method, then XOR-folded
  always_comb begin
    case (lag_pkg::hash_sel_t'(i_sel))
      lag_pkg::HASH_DST_MAC:     key = i_dst_mac;
      lag_pkg::HASH_SRC_DST_MAC: key = i_src_mac ^ i_dst_mac;
      lag_pkg::HASH_SOURCE_NET_ADDRESS_HASH:      key = {16'h0000, i_source_net_address_hash};
      lag_pkg::HASH_DST_IP:      key = {16'h0000, i_dst_ip};
      lag_pkg::HASH_SRC_DST_IP:  key = {16'h0000, i_source_net_address_hash ^ i_dst_ip};
      default:                   key = i_src_mac;
    endcase
    o_hash = '0;
    for (int i = 0; i < 48; i++) begin
      o_hash[i % OUT_W] = o_hash[i % OUT_W] ^ key[i];
    end
  end
endmodule

// >>> link_aggregation_distributor.sv
// Trunk group distributor: membership, lead port, hashing, failover, STP view
//
// Trunking rules this block is built against
// [RULE1] At most two trunk groups, each of two to four member ports.
// [RULE2] Members share one speed, 100 or 1000 Mbps, full duplex only.
// [RULE3] A port may sit in only one trunk group.
// [RULE4] Only the four external ports aggregate; static or LACP groups, two max. GCFG_DYNAMIC_BIT is never read here, so every group is static.
// [RULE5] Member ports need not be contiguous.
// [RULE6] Lowest-numbered member is lead; its settings apply to the whole group.
// [RULE7] Traffic balanced across members; failed links moved to working ones.
// [RULE8] STP sees a group as one link using the lead port's cost and state.
// [RULE9] Redundant groups: STP blocks one whole group like a single port.
// [RULE10] Egress member chosen by hash; method set apart for IP and non-IP.
// [RULE11] Non-IP hash: source, destination, or both MACs; source MAC default.
// [RULE12] IP hash: six MAC or IP choices; source MAC default.
// [RULE13] Static group active only when members chosen and enabled; default off.
// [RULE14] Software keeps all members in one VLAN, moving the group whole.
// [RULE15] The far switch configures its matching ports as trunks too.
// [RULE16] Enable trunk before cabling; disable members before removing trunk.
// [RULE17] Hash reduced modulo active member count for stable flows.
// [RULE18] Received frames on members count as arriving on the logical trunk.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module link_aggregation_distributor #(
  parameter int HASH_W = 8
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_ce,
  // Avalon-MM slave
  input  wire logic [5:0]              i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic      [31:0]             o_avs_readdata,
  output logic                         o_avs_waitrequest,
  // Per-port MAC status
  input  wire logic [3:0]              i_link_up,
  input  wire logic [3:0]              i_full_duplex,
  input  wire logic [3:0]              i_speed_1g,
  // STP per-port state from the spanning-tree engine
  input  wire logic [7:0]              i_stp_port_state,
  // Egress request and decision
  input  wire lag_pkg::frame_hdr_t     i_tx_hdr,
  output lag_pkg::egress_t             o_tx_egress,
  // Ingress port mapping
  input  wire logic                    i_rx_valid,
  input  wire logic [1:0]              i_rx_port,
  output logic                         o_rx_valid,
  output logic [2:0]                   o_rx_logical,
  // Effective per-port STP state and active membership
  output logic [7:0]                   o_stp_eff,
  output logic [3:0]                   o_active_member
);
  localparam int NP = lag_pkg::NUM_PORTS;
  localparam int NG = lag_pkg::NUM_GROUPS;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] gcfg_r [NG];
  logic [31:0] dcfg_r;
  logic [3:0]  grp_bad_r [NG];
  logic [31:0] rdata_nxt;
  logic        ack_r;

  logic [3:0] members [NG];
  logic       grp_ok  [NG];
  logic [3:0] live    [NG];
  logic [1:0] lead    [NG];
  logic [2:0] live_cnt [NG];

  // Byte-enable aware write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // One-cycle wait then acknowledge; waitrequest lives in its own flop so the
  // master sees a glitch-free level straight from a register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
    end else if (i_ce) begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
    end
  end
  assign ack_r = ~o_avs_waitrequest;

  // Group config registers; default disabled [RULE13]
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      gcfg_r[0] <= lag_pkg::GCFG_RESET;
      gcfg_r[1] <= lag_pkg::GCFG_RESET;
      dcfg_r    <= lag_pkg::DCFG_RESET; // Source MAC default [RULE11] [RULE12]
    end else if (i_ce && i_avs_write && !ack_r) begin
      case (i_avs_address[5:2])
        lag_pkg::REG_GRP0_CFG: gcfg_r[0] <= merge(gcfg_r[0], i_avs_writedata, i_avs_byteenable);
        lag_pkg::REG_GRP1_CFG: gcfg_r[1] <= merge(gcfg_r[1], i_avs_writedata, i_avs_byteenable);
        lag_pkg::REG_DIST_CFG: dcfg_r    <= merge(dcfg_r, i_avs_writedata, i_avs_byteenable);
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses return a marker word
  always_comb begin
    case (i_avs_address[5:2])
      lag_pkg::REG_GRP0_CFG:  rdata_nxt = gcfg_r[0];
      lag_pkg::REG_GRP1_CFG:  rdata_nxt = gcfg_r[1];
      lag_pkg::REG_DIST_CFG:  rdata_nxt = dcfg_r;
      lag_pkg::REG_PORT_STAT: rdata_nxt = {20'h00000, i_speed_1g, i_full_duplex, i_link_up};
      lag_pkg::REG_GRP_STAT:  rdata_nxt = {16'h0000, grp_bad_r[1], grp_bad_r[0],
                                           live[1], live[0]};
      lag_pkg::REG_LEAD_STP:  rdata_nxt = {24'h000000, o_stp_eff};
      default:                rdata_nxt = lag_pkg::BAD_ADDR_DATA;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_avs_readdata <= '0;
    end else if (i_ce && i_avs_read && !ack_r) begin
      o_avs_readdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Group validity: membership, ownership, speed and duplex checks
  // Bad-reason bits: 0 size, 1 overlap, 2 speed mismatch, 3 half duplex
  logic [3:0] bad_nxt [NG];
  logic [3:0] cleaned [NG];

  generate
    for (genvar g = 0; g < NG; g++) begin : g_grp
      // Any port subset is allowed, contiguous or not [RULE5] [RULE4]
      assign members[g] = gcfg_r[g][lag_pkg::GCFG_MEMBER_LSB +: NP];
      // Group 1 claiming any port already in group 0 is flagged as overlap and kept inactive [RULE3]
      if (g == 0) begin : g_first
        assign cleaned[g] = members[g];
      end else begin : g_rest
        assign cleaned[g] = members[g] & ~members[0];
      end
      always_comb begin
        bad_nxt[g]    = 4'h0;
        bad_nxt[g][0] = ($countones(members[g]) < lag_pkg::MIN_MEMBERS); // [RULE1]
        bad_nxt[g][1] = (cleaned[g] != members[g]); // [RULE3]
        // Speed must match the programmed group speed [RULE2]
        bad_nxt[g][2] = |(members[g] &
                         (i_speed_1g ^ {NP{gcfg_r[g][lag_pkg::GCFG_SPEED_BIT]}}) & i_link_up);
        bad_nxt[g][3] = |(members[g] & ~i_full_duplex & i_link_up); // [RULE2]
      end
      // Enabled and consistent groups are active [RULE13] [RULE1]
      assign grp_ok[g] = gcfg_r[g][lag_pkg::GCFG_ENABLE_BIT] && (bad_nxt[g] == 4'h0);
      // Failed links leave the live set [RULE7]
      assign live[g]     = grp_ok[g] ? (members[g] & i_link_up) : 4'h0;
      assign live_cnt[g] = 3'($countones(live[g]));
      // Lowest-numbered member leads [RULE6]
      always_comb begin
        lead[g] = 2'h0;
        for (int p = NP - 1; p >= 0; p--) begin
          if (members[g][p]) begin
            lead[g] = 2'(p);
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      grp_bad_r[0] <= 4'h0;
      grp_bad_r[1] <= 4'h0;
    end else if (i_ce) begin
      grp_bad_r[0] <= bad_nxt[0];
      grp_bad_r[1] <= bad_nxt[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spanning-tree view: lead port state drives the whole group
  logic [7:0] stp_nxt;
  always_comb begin
    stp_nxt = i_stp_port_state;
    for (int g = 0; g < NG; g++) begin
      for (int p = 0; p < NP; p++) begin
        if (grp_ok[g] && members[g][p]) begin
          // One link to STP; a blocked lead blocks every member [RULE8] [RULE9]
          stp_nxt[p*2 +: 2] = i_stp_port_state[lead[g]*2 +: 2];
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_stp_eff       <= {NP{lag_pkg::STP_DIS}};
      o_active_member <= 4'h0;
    end else if (i_ce) begin
      o_stp_eff       <= stp_nxt; // [RULE8]
      o_active_member <= live[0] | live[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Egress selection
  logic [HASH_W-1:0] hash;
  logic [2:0]        tx_sel;
  logic [1:0]        tx_port_nxt;
  logic              tx_drop_nxt;
  logic [2:0]        pick;

  // Method picked separately for IP and non-IP frames [RULE10]
  always_comb begin
    if (i_tx_hdr.is_ip) begin
      tx_sel = dcfg_r[lag_pkg::DCFG_IP_LSB +: 3]; // [RULE12]
    end else begin
      // Only MAC methods apply to non-IP; others fall back to source MAC [RULE11]
      tx_sel = (dcfg_r[lag_pkg::DCFG_NONIP_LSB +: 3] > 3'(lag_pkg::HASH_SRC_DST_MAC)) ?
               3'(lag_pkg::HASH_SRC_MAC) : dcfg_r[lag_pkg::DCFG_NONIP_LSB +: 3];
    end
  end

  lag_hash #(
    .OUT_W (HASH_W)
  ) u_hash (
    .i_sel     (tx_sel),
    .i_src_mac (i_tx_hdr.src_mac),
    .i_dst_mac (i_tx_hdr.dst_mac),
    .i_source_net_address_hash  (i_tx_hdr.source_net_address_hash),
    .i_dst_ip  (i_tx_hdr.dst_ip),
    .o_hash    (hash)
  );

  // Map destination port to its group, then pick the n-th live member
  always_comb begin
    tx_port_nxt = i_tx_hdr.dest_port;
    tx_drop_nxt = 1'b0;
    pick        = 3'h0;
    for (int g = 0; g < NG; g++) begin
      if (grp_ok[g] && members[g][i_tx_hdr.dest_port]) begin
        if (live_cnt[g] == 3'h0) begin
          tx_drop_nxt = 1'b1; // Whole trunk down
        end else begin
          pick = 3'(hash % live_cnt[g]); // [RULE17]
          for (int p = NP - 1; p >= 0; p--) begin
            // Walk live members only, so dead links carry nothing [RULE7]
            if (live[g][p]) begin
              if (3'($countones(live[g] & ((4'h1 << p) - 4'h1))) == pick) begin
                tx_port_nxt = 2'(p); // [RULE10]
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_egress <= '0;
    end else if (i_ce) begin
      o_tx_egress.valid <= i_tx_hdr.valid;
      o_tx_egress.drop  <= tx_drop_nxt;
      o_tx_egress.port  <= tx_port_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ingress: logical port 0..3 physical, 4+g for trunk g
  logic [2:0] rx_nxt;
  always_comb begin
    rx_nxt = {1'b0, i_rx_port};
    for (int g = 0; g < NG; g++) begin
      if (grp_ok[g] && members[g][i_rx_port]) begin
        rx_nxt = 3'(NP + g); // [RULE18]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rx_valid   <= 1'b0;
      o_rx_logical <= 3'h0;
    end else if (i_ce) begin
      o_rx_valid   <= i_rx_valid;
      o_rx_logical <= rx_nxt;
    end
  end
endmodule

// >>> lag_checker.sv
// Port-level assertions for the trunk distributor
`timescale 1ns/1ns
module lag_checker (
  input wire logic                i_clk,
  input wire logic                i_srst,
  input wire logic                i_ce,
  input wire logic [5:0]          i_avs_address,
  input wire logic                i_avs_read,
  input wire logic                i_avs_write,
  input wire logic [31:0]         o_avs_readdata,
  input wire logic                o_avs_waitrequest,
  input wire logic [3:0]          i_link_up,
  input wire logic [3:0]          i_full_duplex,
  input wire lag_pkg::frame_hdr_t i_tx_hdr,
  input wire lag_pkg::egress_t    o_tx_egress,
  input wire logic                i_rx_valid,
  input wire logic [1:0]          i_rx_port,
  input wire logic [2:0]          o_rx_logical,
  input wire logic [3:0]          o_active_member
);
  logic [1:0] dp_q;
  // Target held back one cycle; the registered live set already lines up with the pick
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dp_q <= 2'h0;
    end else if (i_ce) begin
      dp_q <= i_tx_hdr.dest_port;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////////////////
  bus_ack_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce
    |=> !o_avs_waitrequest) else $error("access not acknowledged");
  ack_pulse_a: assert property (!o_avs_waitrequest && i_ce |=> o_avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  bad_read_a: assert property (i_avs_read && o_avs_waitrequest && i_ce
    && i_avs_address[5:2] > 4'h5 |=> o_avs_readdata == lag_pkg::BAD_ADDR_DATA)
    else $error("unmapped read value wrong");
  data_stand_a: assert property (i_ce && !(i_avs_read && o_avs_waitrequest)
    |=> $stable(o_avs_readdata)) else $error("read data moved without a read");
  egress_live_a: assert property (o_tx_egress.valid && !o_tx_egress.drop
    && o_active_member[dp_q] |-> o_active_member[o_tx_egress.port])
    else $error("frame sent to a dead member");
  rx_trunk_a: assert property (i_ce && i_rx_valid && o_active_member[i_rx_port]
    |=> o_rx_logical[2]) else $error("member frame not mapped to trunk");
  half_dup_a: assert property ((i_ce && $stable(i_link_up) && $stable(i_full_duplex))[*3]
    |-> (o_active_member & i_link_up & ~i_full_duplex) == 4'h0)
    else $error("half duplex member active");
  link_down_a: assert property ((i_ce && $stable(i_link_up))[*3]
    |-> (o_active_member & ~i_link_up) == 4'h0) else $error("down link still active");
endmodule
bind link_aggregation_distributor lag_checker u_chk (.i_clk(i_clk), .i_srst(i_srst),
  .i_ce(i_ce), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_link_up(i_link_up),
  .i_full_duplex(i_full_duplex), .i_tx_hdr(i_tx_hdr), .o_tx_egress(o_tx_egress),
  .i_rx_valid(i_rx_valid), .i_rx_port(i_rx_port), .o_rx_logical(o_rx_logical),
  .o_active_member(o_active_member));

// >>> far_switch_model.sv
// Far switch: link status of its trunk ports as seen by our MACs
`timescale 1ns/1ns
module far_switch_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_cabled,
  input  wire logic [3:0] i_half,
  input  wire logic [3:0] i_slow,
  output logic      [3:0] o_link_up,
  output logic      [3:0] o_full_duplex,
  output logic      [3:0] o_speed_1g
);
  // Far ports are trunks too; link rises only once cabled
  always_ff @(posedge i_clk) begin
    o_link_up <= i_cabled;
  end
  // Uncabled ports show a toggling speed/duplex, so nothing may rely on them
  always_ff @(posedge i_clk) begin
    o_full_duplex <= i_cabled ? ~i_half : ~o_full_duplex;
    o_speed_1g    <= i_cabled ? ~i_slow : ~o_speed_1g;
  end
endmodule

// >>> link_aggregation_distributor_tb.sv
// Self-checking bench for the trunk distributor
`timescale 1ns/1ns
module link_aggregation_distributor_tb;
  localparam logic [47:0] SM = 48'h1234_5678_9a01;
  localparam logic [47:0] DM = 48'h0f1e_2d3c_4b5a;
  localparam logic [31:0] SI = 32'hc0a8_0105;
  localparam logic [31:0] DI = 32'h0a00_0a37;
  logic                clk = 1'b0;
  logic                srst, rd, wr, wait_o, rx_v, rx_vo;
  logic [5:0]          addr;
  logic [31:0]         wdata, rdata, rq;
  logic [3:0]          link, fdx, spd, cab, half, slow, act;
  logic [7:0]          stp, stp_o;
  logic [1:0]          rx_p;
  logic [2:0]          rx_l;
  lag_pkg::frame_hdr_t hdr;
  lag_pkg::egress_t    egr;
  int                  miscompares, n_tests, cycles;
  always #5 clk = ~clk;
  link_aggregation_distributor #(.HASH_W(8)) dut (.i_clk(clk), .i_srst(srst), .i_ce(1'b1),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_o),
    .i_link_up(link), .i_full_duplex(fdx), .i_speed_1g(spd), .i_stp_port_state(stp),
    .i_tx_hdr(hdr), .o_tx_egress(egr), .i_rx_valid(rx_v), .i_rx_port(rx_p),
    .o_rx_valid(rx_vo), .o_rx_logical(rx_l), .o_stp_eff(stp_o), .o_active_member(act));
  far_switch_model far (.i_clk(clk), .i_cabled(cab), .i_half(half), .i_slow(slow),
    .o_link_up(link), .o_full_duplex(fdx), .o_speed_1g(spd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Avalon cycle: hold until waitrequest is sampled low, then release
  task automatic bus(logic w, logic [3:0] idx, logic [31:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wait_o !== 1'b0);
    rq = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdc(logic [3:0] idx, logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk("register", e, rq);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [7:0] fold(logic [47:0] v);
    fold = v[7:0] ^ v[15:8] ^ v[23:16] ^ v[31:24] ^ v[39:32] ^ v[47:40];
  endfunction
  // Frame to dp; expected pick is the k-th live member, k = hash mod live count
  task automatic tx(logic ip, logic [1:0] dp, logic [3:0] mem, int m);
    logic [7:0] h;
    logic [3:0] lv;
    int         k;
    int         p;
    if (!ip && m > 2) m = 0;
    h = m == 1 ? fold(DM) : m == 2 ? fold(SM) ^ fold(DM) : m == 3 ? fold({16'h0, SI}) :
        m == 4 ? fold({16'h0, DI}) : m == 5 ? fold({16'h0, SI ^ DI}) : fold(SM);
    lv = mem & cab;
    p = dp;
    if (mem[dp] && lv != 4'h0) begin
      k = h % $countones(lv);
      for (int i = 0; i < 4; i++) if (lv[i]) begin
        if (k == 0) p = i;
        k--;
      end
    end
    @(posedge clk);
    hdr <= '{1'b1, ip, SM, DM, SI, DI, dp};
    @(posedge clk);
    @(negedge clk);
    if (mem[dp] && lv == 4'h0) chk("drop", 2'h3, {egr.valid, egr.drop});
    else chk("egress", {2'h2, p[1:0]}, egr);
  endtask
  task automatic rx(logic [1:0] p, logic [2:0] e);
    @(posedge clk);
    rx_v <= 1'b1;
    rx_p <= p;
    @(posedge clk);
    rx_v <= 1'b0;
    @(negedge clk);
    chk("rx", {1'b1, e}, {rx_vo, rx_l});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    {srst, rd, wr, rx_v, rx_p, addr, wdata, stp, cab, half, slow} = '0;
    hdr = '0;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("reset", {8'hff, 4'h0, 1'b1}, {stp_o, act, wait_o});
    rdc(lag_pkg::REG_GRP0_CFG, lag_pkg::GCFG_RESET);
    rdc(lag_pkg::REG_DIST_CFG, lag_pkg::DCFG_RESET);
    rdc(4'h9, lag_pkg::BAD_ADDR_DATA);
    // Trunk configured before cabling; members 0,1,3 are not contiguous
    bus(1'b1, lag_pkg::REG_GRP0_CFG, 32'h4b);
    cab <= 4'hf;
    settle;
    chk("active", 4'h0, act);
    bus(1'b1, lag_pkg::REG_GRP0_CFG, 32'h5b);
    bus(1'b1, lag_pkg::REG_GRP1_CFG, 32'h54);
    settle;
    chk("active", 4'hb, act);
    bus(1'b1, lag_pkg::REG_GRP_STAT, 32'h0);
    rdc(lag_pkg::REG_GRP_STAT, 32'h100b);
    for (int m = 0; m < 6; m++) begin
      bus(1'b1, lag_pkg::REG_DIST_CFG, (m << 4) | m);
      tx(1'b1, 2'h1, 4'hb, m);
      tx(1'b0, 2'h3, 4'hb, m);
    end
    tx(1'b1, 2'h2, 4'hb, 5);
    stp <= 8'h01;
    settle;
    chk("stp", 8'h45, stp_o);
    rx(2'h3, 3'h4);
    rx(2'h2, 3'h2);
    cab <= 4'hd;
    settle;
    tx(1'b1, 2'h3, 4'hb, 5);
    cab <= 4'h4;
    settle;
    tx(1'b1, 2'h0, 4'hb, 5);
    cab <= 4'hf;
    half <= 4'h8;
    settle;
    chk("active", 4'h0, act);
    half <= 4'h0;
    slow <= 4'h1;
    settle;
    chk("active", 4'h0, act);
    slow <= 4'h0;
    bus(1'b1, lag_pkg::REG_GRP1_CFG, 32'h53);
    settle;
    chk("active", 4'hb, act);
    // Each group is regrouped as a whole, never member by member
    bus(1'b1, lag_pkg::REG_GRP0_CFG, 32'h53);
    bus(1'b1, lag_pkg::REG_GRP1_CFG, 32'h5c);
    stp <= 8'h10;
    settle;
    chk("active", 4'hf, act);
    chk("stp", 8'h50, stp_o);
    complete_run;
  end
endmodule
